//--- rtl/scl_bank.sv
// Configuration latch bank of a four-channel serializer, AXI4-Lite slave.
// Assumes one 40 MHz core clock and synchronous transmit clock inputs.
// Summary of operation
// - Secondary driver enable resets 0; 1 transmits, 0 disables.
// - Primary driver enable resets 0; 1 transmits, 0 disables.
// - A disabled driver is powered down.
// - Both drivers off powers down the channel logic.
// - Reset low disables every driver on all channels.
// - Recenter latch resets 1; writing 0 recenters the phase buffer.
// - Recenter request is synchronised on transmit clock rising edges.
// - Recenter latch returns to 1 by itself after use.
// - Per-address global enable resets 1; 0 excludes from global writes.
// - Force bit in a global write overrides per-address global enables.
// - Thirteen 5-bit latches: four channels of three, one mask; three global addresses write into channel latches.
// - Clock select resets 1; 1 bypasses phase buffer, 0 uses transmit clock.
// - PLL rate resets 0; 0 multiplies by 10, 1 by 20, dual edge only while clock select is also 1.
// - Self-test disable resets 1; writing 0 enables self-test.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.svh"
module scl_bank (
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   input  wire logic [3:0]  TRANSMIT_INPUT_CLOCK,
   output var  logic [3:0]  PRIMARY_DRIVER_ENABLE,
   output var  logic [3:0]  SECONDARY_DRIVER_ENABLE,
   output var  logic [3:0]  PRIMARY_DRIVER_POWERDOWN,
   output var  logic [3:0]  SECONDARY_DRIVER_POWERDOWN,
   output var  logic [3:0]  CHANNEL_POWERDOWN,
   output var  logic [3:0]  INPUT_CLOCK_SELECT,
   output var  logic [3:0]  PHASE_BUFFER_BYPASS,
   output var  logic [3:0]  PLL_MULTIPLIER_SELECT,
   output var  logic [3:0]  DUAL_EDGE_CAPTURE,
   output var  logic [3:0]  SELFTEST_DISABLE,
   output var  logic [3:0]  PHASE_BUFFER_RECENTER
);

   // Bus channel holding registers and write mask
   logic        aw_full_ff;
   logic        w_full_ff;
   logic [5:0]  wr_idx_ff;
   logic [4:0]  wdata_ff;
   logic        wstrb_ff;
   logic        awready_ff;
   logic        wready_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [4:0]  mask_ff;

   // Output flops
   logic [3:0]  pri_ff;
   logic [3:0]  sec_ff;
   logic [3:0]  clk_sel_ff;
   logic [3:0]  rate_ff;
   logic [3:0]  dual_ff;
   logic [3:0]  selftest_ff;

   logic        aw_hs;
   logic        w_hs;
   logic        ar_hs;
   logic        r_hs;
   logic        b_hs;
   logic        wr_commit;
   logic        wr_mapped;
   logic        wr_apply;
   logic        nxt_aw_full;
   logic        nxt_w_full;
   logic [5:0]  rd_idx;
   logic        rd_latch;
   logic        rd_status;
   logic [31:0] status_word;
   logic [31:0] nxt_rdata;
   logic [1:0]  nxt_rresp;

   logic [4:0]  latch_w [`SCL_NUM_LATCH];
   logic [11:0] direct_hit;
   logic [11:0] glob_hit;
   logic [3:0]  fire;
   logic [3:0]  recenter_req;
   logic [3:0]  nxt_pri;
   logic [3:0]  nxt_sec;
   logic [3:0]  nxt_clk_sel;
   logic [3:0]  nxt_rate;
   logic [3:0]  nxt_dual;
   logic [3:0]  nxt_selftest;

   // Handshakes and write decode
   assign aw_hs     = S_AXI_AWVALID & awready_ff;
   assign w_hs      = S_AXI_WVALID & wready_ff;
   assign ar_hs     = S_AXI_ARVALID & arready_ff;
   assign r_hs      = rvalid_ff & S_AXI_RREADY;
   assign b_hs      = bvalid_ff & S_AXI_BREADY;
   assign wr_commit = aw_full_ff & w_full_ff & ~bvalid_ff;
   assign wr_mapped = (wr_idx_ff <= `SCL_IDX_STATUS);
   assign wr_apply  = wr_commit & wr_mapped & wstrb_ff;

   assign nxt_aw_full = wr_commit ? 1'b0 : (aw_hs | aw_full_ff);
   assign nxt_w_full  = wr_commit ? 1'b0 : (w_hs | w_full_ff);

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         wr_idx_ff  <= 6'h00;
         wdata_ff   <= 5'h00;
         wstrb_ff   <= 1'b0;
      end else begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff  <= nxt_w_full;
         awready_ff <= ~nxt_aw_full;
         wready_ff  <= ~nxt_w_full;
         if (aw_hs) begin
            wr_idx_ff <= S_AXI_AWADDR[7:2];
         end
         if (w_hs) begin
            wdata_ff <= S_AXI_WDATA[4:0];
            wstrb_ff <= S_AXI_WSTRB[0];
         end
      end
   end

   // Write response
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= scl_pkg::SCL_RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_mapped ? scl_pkg::SCL_RESP_OKAY : scl_pkg::SCL_RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Write mask for global writes
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         mask_ff <= `SCL_RST_WRITE_MASK;
      end else if (wr_apply && wr_idx_ff == `SCL_IDX_WRITE_MASK) begin
         mask_ff <= wdata_ff;
      end
   end

   // Channel latches, three per channel
   for (genvar i = 0; i < `SCL_NUM_LATCH; i++) begin : g_latch
      localparam int BANK = i % `SCL_BANKS_PER_CH;
      localparam int CH = i / `SCL_BANKS_PER_CH;
      localparam logic [4:0] RST = (BANK == 0) ? `SCL_RST_STATIC_BANK0 :
                                   (BANK == 1) ? `SCL_RST_STATIC_BANK1 : `SCL_RST_DYNAMIC_BANK;
      localparam logic [5:0] GIDX = 6'(`SCL_IDX_GLOBAL_STATIC_BANK0 + BANK);
      logic [4:0] bank_ff;
      logic [4:0] nxt_bank;
      logic [3:0] masked;
      logic       restore;

      assign direct_hit[i] = wr_apply & (wr_idx_ff == 6'(i));
      assign glob_hit[i]   = wr_apply & (wr_idx_ff == GIDX) &
                             (bank_ff[`SCL_BIT_GLOBAL] | wdata_ff[`SCL_BIT_GLOBAL]);
      assign masked  = (wdata_ff[4:1] & mask_ff[4:1]) | (bank_ff[4:1] & ~mask_ff[4:1]);
      assign restore = (BANK == 2) & fire[CH];
      assign nxt_bank = direct_hit[i] ? wdata_ff :
                        glob_hit[i]   ? {masked[3:1], masked[0] | (restore & ~mask_ff[1]),
                                         bank_ff[`SCL_BIT_GLOBAL]} :
                        restore       ? (bank_ff | 5'h02) : bank_ff;
      assign latch_w[i] = bank_ff;

      always_ff @(posedge CORE_CLK or negedge RESETN) begin
         if (!RESETN) begin
            bank_ff <= RST;
         end else begin
            bank_ff <= nxt_bank;
         end
      end
   end

   // Per-channel decode of bank fields
   for (genvar c = 0; c < `SCL_NUM_CHAN; c++) begin : g_chan
      scl_pkg::scl_dyn_bank_t dyn;
      scl_pkg::scl_clk_bank_t clk_bank;

      assign dyn      = latch_w[3*c+2];
      assign clk_bank = latch_w[3*c+1];
      assign recenter_req[c] = ~dyn.phase_buffer_recenter;
      assign nxt_pri[c]      = dyn.primary_driver_enable;
      assign nxt_sec[c]      = dyn.secondary_driver_enable;
      assign nxt_selftest[c] = dyn.selftest_disable;
      assign nxt_clk_sel[c]  = clk_bank.input_clock_select;
      assign nxt_rate[c]     = clk_bank.pll_multiplier_select;
      assign nxt_dual[c]     = clk_bank.pll_multiplier_select & clk_bank.input_clock_select;

      scl_recenter_sync u_sync (
         .clk    (CORE_CLK),
         .rst_n  (RESETN),
         .req    (recenter_req[c]),
         .tx_clk (TRANSMIT_INPUT_CLOCK[c]),
         .fire   (fire[c])
      );
   end

   // Registered channel outputs
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pri_ff      <= 4'h0;
         sec_ff      <= 4'h0;
         clk_sel_ff  <= 4'hf;
         rate_ff     <= 4'h0;
         dual_ff     <= 4'h0;
         selftest_ff <= 4'hf;
      end else begin
         pri_ff      <= nxt_pri;
         sec_ff      <= nxt_sec;
         clk_sel_ff  <= nxt_clk_sel;
         rate_ff     <= nxt_rate;
         dual_ff     <= nxt_dual;
         selftest_ff <= nxt_selftest;
      end
   end

   // Power-down flags mirror the enable flops
   logic [3:0] pri_pd_ff;
   logic [3:0] sec_pd_ff;
   logic [3:0] chan_pd_ff;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pri_pd_ff  <= 4'hf;
         sec_pd_ff  <= 4'hf;
         chan_pd_ff <= 4'hf;
      end else begin
         pri_pd_ff  <= ~nxt_pri;
         sec_pd_ff  <= ~nxt_sec;
         chan_pd_ff <= ~(nxt_pri | nxt_sec);
      end
   end

   // Read path
   assign rd_idx      = S_AXI_ARADDR[7:2];
   assign rd_latch    = (rd_idx < `SCL_IDX_STATUS);
   assign rd_status   = (rd_idx == `SCL_IDX_STATUS);
   assign status_word = {16'h0000, recenter_req, chan_pd_ff, sec_ff, pri_ff};
   assign nxt_rdata   = rd_status ? status_word : 32'h0000_0000;
   assign nxt_rresp   = (rd_latch | rd_status) ? scl_pkg::SCL_RESP_OKAY : scl_pkg::SCL_RESP_SLVERR;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= scl_pkg::SCL_RESP_OKAY;
      end else if (ar_hs) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end else if (r_hs) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
      end
   end

   // Port drive
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY  = wready_ff;
   assign S_AXI_BVALID  = bvalid_ff;
   assign S_AXI_BRESP   = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID  = rvalid_ff;
   assign S_AXI_RDATA   = rdata_ff;
   assign S_AXI_RRESP   = rresp_ff;
   assign PRIMARY_DRIVER_ENABLE      = pri_ff;
   assign SECONDARY_DRIVER_ENABLE    = sec_ff;
   assign PRIMARY_DRIVER_POWERDOWN   = pri_pd_ff;
   assign SECONDARY_DRIVER_POWERDOWN = sec_pd_ff;
   assign CHANNEL_POWERDOWN          = chan_pd_ff;
   assign INPUT_CLOCK_SELECT         = clk_sel_ff;
   assign PHASE_BUFFER_BYPASS        = clk_sel_ff;
   assign PLL_MULTIPLIER_SELECT      = rate_ff;
   assign DUAL_EDGE_CAPTURE          = dual_ff;
   assign SELFTEST_DISABLE           = selftest_ff;
   assign PHASE_BUFFER_RECENTER      = fire;

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   a_sec_follows_write: assert property (direct_hit[2] |-> ##2 (SECONDARY_DRIVER_ENABLE[0] == $past(wdata_ff[3], 2)))
      else $error("secondary enable does not follow write");
   a_pri_follows_write: assert property (direct_hit[5] |-> ##2 (PRIMARY_DRIVER_ENABLE[1] == $past(wdata_ff[2], 2)))
      else $error("primary enable does not follow write");
   a_driver_pd_match: assert property ((PRIMARY_DRIVER_POWERDOWN == ~PRIMARY_DRIVER_ENABLE) && (SECONDARY_DRIVER_POWERDOWN == ~SECONDARY_DRIVER_ENABLE))
      else $error("driver power-down mismatches enable");
   a_channel_pd_match: assert property (CHANNEL_POWERDOWN == ~(PRIMARY_DRIVER_ENABLE | SECONDARY_DRIVER_ENABLE))
      else $error("channel power-down mismatches enables");
   a_reset_drivers_off: assert property (@(posedge CORE_CLK) disable iff (1'b0) !RESETN |-> (PRIMARY_DRIVER_ENABLE == 4'h0 && SECONDARY_DRIVER_ENABLE == 4'h0))
      else $error("driver enabled during reset");
   a_recenter_restore: assert property ((fire[0] && !direct_hit[2] && !(glob_hit[2] && mask_ff[1])) |=> latch_w[2][`SCL_BIT_RECENTER])
      else $error("recenter latch did not self clear");
   a_glen_excluded: assert property ((wr_apply && wr_idx_ff == `SCL_IDX_GLOBAL_STATIC_BANK0 && !latch_w[0][0] && !wdata_ff[0]) |=> $stable(latch_w[0]))
      else $error("excluded address took a global write");
   a_force_update: assert property ((wr_apply && wr_idx_ff == `SCL_IDX_GLOBAL_DYNAMIC_BANK && wdata_ff[0] && mask_ff == 5'h1f && !fire[3]) |=> (latch_w[11][4:1] == $past(wdata_ff[4:1])))
      else $error("forced global write missed a channel");
   a_unmapped_slverr: assert property ((wr_commit && !wr_mapped) |=> (S_AXI_BVALID && S_AXI_BRESP == 2'b10))
      else $error("unmapped write not answered with error");
   a_clk_sel_follow: assert property (direct_hit[1] |-> ##2 (INPUT_CLOCK_SELECT[0] == $past(wdata_ff[2], 2) && PHASE_BUFFER_BYPASS[0] == INPUT_CLOCK_SELECT[0]))
      else $error("clock select does not follow write");
   a_rate_follow: assert property (direct_hit[1] |-> ##2 (PLL_MULTIPLIER_SELECT[0] == $past(wdata_ff[1], 2)))
      else $error("pll select does not follow write");
   a_selftest_follow: assert property (direct_hit[8] |-> ##2 (SELFTEST_DISABLE[2] == $past(wdata_ff[4], 2)))
      else $error("self-test disable does not follow write");
   a_recenter_start: assert property ((direct_hit[2] && !wdata_ff[1]) |=> recenter_req[0])
      else $error("recenter write did not raise request");

   c_direct_write: cover property (direct_hit[2]);
   c_forced_global: cover property (glob_hit[2] && !latch_w[2][0]);
   c_recenter_fire: cover property (fire[0]);
   c_status_read: cover property (ar_hs && rd_status);

endmodule // scl_bank
`default_nettype wire

//--- rtl/scl_defines.svh
// Offsets, field positions and reset values of the configuration latch bank.
// Assumes byte address = 4 * latch index on a 32-bit register bus.
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

`define SCL_IDX_CHAN_A_STATIC_BANK0 6'h00
`define SCL_IDX_CHAN_A_STATIC_BANK1 6'h01
`define SCL_IDX_CHAN_A_DYNAMIC_BANK 6'h02
`define SCL_IDX_CHAN_B_STATIC_BANK0 6'h03
`define SCL_IDX_CHAN_B_STATIC_BANK1 6'h04
`define SCL_IDX_CHAN_B_DYNAMIC_BANK 6'h05
`define SCL_IDX_CHAN_C_STATIC_BANK0 6'h06
`define SCL_IDX_CHAN_C_STATIC_BANK1 6'h07
`define SCL_IDX_CHAN_C_DYNAMIC_BANK 6'h08
`define SCL_IDX_CHAN_D_STATIC_BANK0 6'h09
`define SCL_IDX_CHAN_D_STATIC_BANK1 6'h0a
`define SCL_IDX_CHAN_D_DYNAMIC_BANK 6'h0b
`define SCL_IDX_GLOBAL_STATIC_BANK0 6'h0c
`define SCL_IDX_GLOBAL_STATIC_BANK1 6'h0d
`define SCL_IDX_GLOBAL_DYNAMIC_BANK 6'h0e
`define SCL_IDX_WRITE_MASK          6'h0f
`define SCL_IDX_STATUS              6'h10

`define SCL_NUM_CHAN     4
`define SCL_NUM_LATCH    12
`define SCL_BANKS_PER_CH 3

`define SCL_RST_STATIC_BANK0 5'h1f
`define SCL_RST_STATIC_BANK1 5'h0d
`define SCL_RST_DYNAMIC_BANK 5'h13
`define SCL_RST_WRITE_MASK   5'h1f

`define SCL_BIT_GLOBAL   0
`define SCL_BIT_RECENTER 1
`define SCL_BIT_PRIMARY  2
`define SCL_BIT_SECOND   3
`define SCL_BIT_SELFTEST 4
`define SCL_BIT_PLL_RATE 1
`define SCL_BIT_CLK_SEL  2

`endif

//--- rtl/scl_pkg.sv
// Types shared by the configuration latch bank.
// Assumes nothing beyond a SystemVerilog compiler.
package scl_pkg;

   typedef struct packed {
      logic selftest_disable;
      logic secondary_driver_enable;
      logic primary_driver_enable;
      logic phase_buffer_recenter;
      logic global_participate;
   } scl_dyn_bank_t;

   typedef struct packed {
      logic fixed_x;
      logic fixed_zero;
      logic input_clock_select;
      logic pll_multiplier_select;
      logic global_participate;
   } scl_clk_bank_t;

   typedef enum logic [1:0] {
      SCL_RESP_OKAY   = 2'b00,
      SCL_RESP_SLVERR = 2'b10
   } scl_resp_t;

endpackage

//--- rtl/scl_recenter_sync.sv
// Recenter request synchroniser for one channel.
// Assumes tx_clk is sampled as a synchronous input of the core clock.
`timescale 1ns/1ps
`default_nettype none
module scl_recenter_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic req,
   input  wire logic tx_clk,
   output var  logic fire
);
   logic clk_prev_ff;
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic fire_ff;
   logic clk_edge;

   assign clk_edge = tx_clk & ~clk_prev_ff;
   assign fire     = fire_ff;

   // Request sampled only at transmit clock rising edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev_ff <= 1'b0;
         s1_ff       <= 1'b0;
         s2_ff       <= 1'b0;
         s3_ff       <= 1'b0;
         fire_ff     <= 1'b0;
      end else begin
         clk_prev_ff <= tx_clk;
         fire_ff     <= clk_edge & s2_ff & ~s3_ff;
         if (clk_edge) begin
            s1_ff <= req;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_fire_on_edge: assert property (fire_ff |-> $past(clk_edge))
      else $error("recenter fired without transmit clock edge");
   a_fire_single: assert property (fire_ff |=> !fire_ff)
      else $error("recenter pulse longer than one cycle");

endmodule // scl_recenter_sync
`default_nettype wire

//--- dv/scl_txclk_src.sv
// Transmit clock source standing in for the serializer datapath side.
// Assumes the core clock; a channel toggles every three cycles while run is high.
`timescale 1ns/1ps
`default_nettype none
module scl_txclk_src (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] run,
   output var  logic [3:0] tx_clk
);
   logic [1:0] div_ff;
   // Stopped channels stand still low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 2'h0;
         tx_clk <= 4'h0;
      end else begin
         div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
         if (div_ff == 2'h2) tx_clk <= (tx_clk ^ run) & run;
      end
   end
endmodule // scl_txclk_src
`default_nettype wire

//--- dv/test_serializer_config_latch_bank.sv
// Self-checking bench for the configuration latch bank.
// Assumes scl_bank as device and scl_txclk_src as transmit clock source.
`timescale 1ns/1ps
`default_nettype none
module test_serializer_config_latch_bank;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0]  strb = 4'hf, run = 4'h0;
   logic        awr, wr, bv, arr, rv;
   logic [1:0]  br, rr;
   logic [31:0] rd;
   logic [3:0]  pri, sec, ppd, spd, cpd, ics, byp, pll, dual, std, rct, txc;
   logic [39:0] pins;
   logic [4:0]  bk [4][3];
   logic [4:0]  msk;
   logic [15:0] seed = 16'hd92c;
   int          errors = 0;
   int          comparisons = 0;

   assign pins = {pri, sec, ppd, spd, cpd, ics, byp, pll, dual, std};
   always #12.5 clk = ~clk;

   scl_txclk_src SRC (.clk(clk), .rst_n(rst_n), .run(run), .tx_clk(txc));
   scl_bank DUT (.CORE_CLK(clk), .RESETN(rst_n),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
      .TRANSMIT_INPUT_CLOCK(txc), .PRIMARY_DRIVER_ENABLE(pri), .SECONDARY_DRIVER_ENABLE(sec),
      .PRIMARY_DRIVER_POWERDOWN(ppd), .SECONDARY_DRIVER_POWERDOWN(spd),
      .CHANNEL_POWERDOWN(cpd), .INPUT_CLOCK_SELECT(ics), .PHASE_BUFFER_BYPASS(byp),
      .PLL_MULTIPLIER_SELECT(pll), .DUAL_EDGE_CAPTURE(dual), .SELFTEST_DISABLE(std),
      .PHASE_BUFFER_RECENTER(rct));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [39:0] pins_exp();
      logic [3:0] p, s, cs, pl, st;
      for (int c = 0; c < 4; c++) begin
         p[c] = bk[c][2][2];
         s[c] = bk[c][2][3];
         cs[c] = bk[c][1][2];
         pl[c] = bk[c][1][1];
         st[c] = bk[c][2][4];
      end
      return {p, s, ~p, ~s, ~p & ~s, cs, cs, pl, pl & cs, st};
   endfunction

   function automatic logic [31:0] stat_exp(input logic [3:0] pend);
      logic [39:0] e;
      e = pins_exp();
      return {16'h0, pend, e[23:20], e[35:32], e[39:36]};
   endfunction

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic init_model();
      for (int c = 0; c < 4; c++) begin
         bk[c][0] = 5'h1f;
         bk[c][1] = 5'h0d;
         bk[c][2] = 5'h13;
      end
      msk = 5'h1f;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv && n < 50);
      resp = br;
      bry <= 1'b0;
      if (n >= 50) chk(40'h1, 40'h0, "write hang");
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 50);
      d = rd;
      resp = rr;
      rry <= 1'b0;
      if (n >= 50) chk(40'h1, 40'h0, "read hang");
   endtask

   // Writes one latch and mirrors it in the model, global copies included
   task automatic put(input int i, input logic [4:0] d);
      logic [1:0] r;
      wr_reg(8'(i * 4), {27'h0, d}, r);
      chk(40'(r), 40'h0, "write response");
      if (i < 12) bk[i / 3][i % 3] = d;
      else if (i == 15) msk = d;
      else for (int c = 0; c < 4; c++)
         if (bk[c][i - 12][0] | d[0])
            bk[c][i - 12][4:1] = (bk[c][i - 12][4:1] & ~msk[4:1]) | (d[4:1] & msk[4:1]);
   endtask

   task automatic chk_pins(input string msg);
      repeat (2) @(posedge clk);
      chk(pins, pins_exp(), msg);
   endtask

   task automatic chk_stat(input logic [3:0] pend);
      logic [31:0] d;
      logic [1:0] r;
      rd_reg(8'h40, d, r);
      chk(40'(d), 40'(stat_exp(pend)), "status");
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      chk(40'h1, 40'h0, "watchdog expired");
      give_verdict();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] seenr;
      int ch, n;
      init_model();
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk_pins("reset pins");
      chk_stat(4'h0);
      $display("test reset values done");
      for (int k = 0; k < 24; k++) begin
         seed = lfsr(seed);
         ch = int'(seed[7:6]);
         put(ch * 3, seed[4:0] & 5'h1b);
         put(ch * 3 + 1, seed[12:8] & 5'h17);
         seed = lfsr(seed);
         put(ch * 3 + 2, seed[4:0] | 5'h02);
         chk_pins("direct write");
         rd_reg(8'(ch * 12 + 8), d, r);
         chk(40'({r, d}), 40'h0, "write-only read");
      end
      $display("test random direct writes done");
      for (int g = 0; g < 3; g++) begin
         for (int c = 0; c < 4; c++) put(c * 3 + g, {bk[c][g][4:1], c[0]});
         for (int f = 0; f < 2; f++) begin
            seed = lfsr(seed);
            put(15, seed[4:0]);
            seed = lfsr(seed);
            put(12 + g, {seed[4:1] & (g == 0 ? 4'hd : g == 1 ? 4'hb : 4'hf) | (g == 2 ? 4'h1 : 4'h0), f[0]});
            chk_pins("global write");
         end
      end
      $display("test global writes done");
      strb <= 4'h0;
      wr_reg(8'h08, 32'h0000000e, r);
      strb <= 4'hf;
      chk(40'(r), 40'h0, "strobe off response");
      chk_pins("strobe off");
      wr_reg(8'h40, 32'h0000001f, r);
      chk(40'(r), 40'h0, "status write response");
      wr_reg(8'h44, 32'h0000001f, r);
      chk(40'(r), 40'h2, "unmapped write response");
      rd_reg(8'h44, d, r);
      chk(40'({r, d}), {6'h0, 2'h2, 32'h0}, "unmapped read");
      chk_pins("after refused writes");
      $display("test refused accesses done");
      for (int c = 0; c < 4; c++) begin
         put(c * 3 + 2, bk[c][2] & 5'h1d);
         bk[c][2][1] = 1'b1;
         seenr = 4'h0;
         repeat (20) begin
            @(posedge clk);
            seenr = seenr | rct;
         end
         chk(40'(seenr), 40'h0, "recenter without transmit clock");
         chk_stat(4'h1 << c);
         run <= 4'hf;
         n = 0;
         while (rct[c] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         chk(40'(rct), 40'(4'h1 << c), "recenter pulse");
         @(posedge clk);
         chk(40'(rct), 40'h0, "recenter single pulse");
         run <= 4'h0;
         chk_stat(4'h0);
      end
      $display("test recenter done");
      put(15, 5'h1f);
      put(14, 5'h0f);
      chk_pins("drivers on");
      @(posedge clk);
      rst_n <= 1'b0;
      #2;
      chk(40'({pri, sec, ppd, spd}), 40'h00ff, "drivers in reset");
      init_model();
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk_pins("after second reset");
      $display("test reset in mid-run done");
      give_verdict();
   end
endmodule // test_serializer_config_latch_bank
`default_nettype wire
